// ---- design/eil_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// (R1) Enable instruction sets, disable clears global enable
// (R2) Global enable is status word bit 4
// (R3) Software should prefix disable with repeat
// (R4) Trigger event sets its level's pending flag
// (R5) Eight-bit flag register at port 0x39
// (R6) Reset leaves flag register untouched
// (R7) Fixed mapping of events to flag bits
// (R8) Comparator enable reroutes levels six and seven
// (R9) Clear mask bit blocks that level's service
// (R10) Mask lives in control register port 0x38
// (R11) Reset clears every mask bit
// (R12) Flags latch events whatever the mask
// (R13) Both registers readable, writable; write sets/clears flags
// (R14) Pending, unmasked flag with enable starts branch
// (R15) Lowest-numbered eligible level wins
// (R16) Vector to level; remaining levels follow by priority
// (R17) Taking branch clears global enable
// (R18) Taking branch clears serviced flag
// (R19) Masked level: no vector, nothing cleared
// (R20) Flags latch while disabled, served after enable
// (R21) Handler software re-enables globally, nesting optional
// (R22) Event beats same-cycle clear of flag
module eil_ctrl
  import eil_pkg::*;
#(
  parameter int PORTF_W = 8
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire eil_port_req_t PORT_REQ_I,
  output logic [PORT_DATA_W-1:0] PORT_RDATA_O,
  input wire logic ENABLE_IRQ_INSTR_I,
  input wire logic DISABLE_IRQ_INSTR_I,
  input wire logic RETURN_FROM_HANDLER_I,
  input wire logic BRANCH_READY_I,
  input wire logic CONVERTER_TIMER_UNDERFLOW_I,
  input wire logic TIMER_ONE_UNDERFLOW_I,
  input wire logic TIMER_TWO_UNDERFLOW_I,
  input wire logic PORTD2_I,
  input wire logic PORTD3_I,
  input wire logic PORTD4_I,
  input wire logic PORTD5_I,
  input wire logic [PORTF_W-1:0] PORTF_I,
  input wire logic CMP_ENABLE_I,
  input wire logic CMP_LEVEL_SIX_I,
  input wire logic CMP_LEVEL_SEVEN_I,
  output logic VECTOR_REQ_O,
  output logic [LEVEL_W-1:0] VECTOR_LEVEL_O,
  output logic [STATUS_W-1:0] STATUS_O,
  output logic HANDLER_ACTIVE_O
);
  logic [PD_W-1:0] pd_sync;
  logic [PORTF_W-1:0] pf_sync;
  logic [PD_W-1:0] pd_prev_reg;
  logic [PORTF_W-1:0] pf_prev_reg;
  logic [WARM_W-1:0] warm_reg;
  logic edges_ok;
  logic [NUM_LEVELS-1:0] ev;
  logic [NUM_LEVELS-1:0] flag_reg;
  logic [NUM_LEVELS-1:0] mask_reg;
  logic [NUM_LEVELS-1:0] cand;
  logic [NUM_LEVELS-1:0] svc_clr;
  logic gie_reg;
  logic gie_next;
  logic take;
  logic cand_valid;
  logic [LEVEL_W-1:0] cand_level;
  logic flag_wr;
  logic mask_wr;
  logic vec_req_reg;
  logic [LEVEL_W-1:0] vec_level_reg;
  logic [PORT_DATA_W-1:0] rdata_reg;
  eil_svc_state_t state_reg;
  eil_svc_state_t state_next;
  logic hact_reg;

  // Pins are asynchronous to the core clock
  eil_sync #(
    .W(PD_W)
  ) u_sync_pd (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .d_i({PORTD5_I, PORTD4_I, PORTD3_I, PORTD2_I}),
    .q_o(pd_sync)
  );

  eil_sync #(
    .W(PORTF_W)
  ) u_sync_pf (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .d_i(PORTF_I),
    .q_o(pf_sync)
  );

  // Edges are ignored until the synchronisers hold real pin levels
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      warm_reg <= '0;
      pd_prev_reg <= '0;
      pf_prev_reg <= '0;
    end else if (CE_I) begin
      warm_reg <= {warm_reg[WARM_W-2:0], 1'b1};
      pd_prev_reg <= pd_sync;
      pf_prev_reg <= pf_sync;
    end
  end

  assign edges_ok = warm_reg[WARM_W-1];

  always_comb begin
    ev = LEVEL_NONE;
    ev[LVL_CONV] = CONVERTER_TIMER_UNDERFLOW_I; // R7
    ev[LVL_TMR1] = TIMER_ONE_UNDERFLOW_I;
    ev[LVL_TMR2] = TIMER_TWO_UNDERFLOW_I;
    ev[LVL_PD2R] = edges_ok & pd_sync[PD_IDX_2] & ~pd_prev_reg[PD_IDX_2];
    ev[LVL_PD3F] = edges_ok & ~pd_sync[PD_IDX_3] & pd_prev_reg[PD_IDX_3];
    ev[LVL_PFF] = edges_ok & (|(~pf_sync & pf_prev_reg));
    if (CMP_ENABLE_I) begin
      ev[LVL_PD4R] = CMP_LEVEL_SIX_I; // R8
      ev[LVL_PD5F] = CMP_LEVEL_SEVEN_I;
    end else begin
      ev[LVL_PD4R] = edges_ok & pd_sync[PD_IDX_4] & ~pd_prev_reg[PD_IDX_4];
      ev[LVL_PD5F] = edges_ok & ~pd_sync[PD_IDX_5] & pd_prev_reg[PD_IDX_5];
    end
  end

  assign flag_wr = PORT_REQ_I.wr && (PORT_REQ_I.addr == PORT_ADDR_FLAGS);
  assign mask_wr = PORT_REQ_I.wr && (PORT_REQ_I.addr == PORT_ADDR_CTRL);

  // Eligible levels: pending and unmasked
  assign cand = flag_reg & mask_reg; // R9 R19

  eil_prio #(
    .N(NUM_LEVELS),
    .W(LEVEL_W)
  ) u_prio (
    .req_i(cand),
    .valid_o(cand_valid),
    .level_o(cand_level)
  );

  // Level-sensitive so that leftovers are served after return
  assign take = gie_reg && cand_valid && BRANCH_READY_I; // R1 R14 R15 R16 R20

  // Flags have no reset so their contents survive it
  genvar g;
  generate
    for (g = 0; g < NUM_LEVELS; g++) begin : g_flag
      assign svc_clr[g] = take && (cand_level == LEVEL_W'(g)); // R18
      always_ff @(posedge REF_CLK_I) begin // R6
        if (CE_I) begin
          // Event ORed last so it beats software or service clears
          flag_reg[g] <= ev[g] | ((flag_wr ? PORT_REQ_I.wdata[g] : flag_reg[g]) & ~svc_clr[g]); // R4 R12 R13 R22
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mask_reg <= MASK_RESET; // R11
    end else if (CE_I && mask_wr) begin
      mask_reg <= PORT_REQ_I.wdata[MASK_LSB +: NUM_LEVELS]; // R10 R13
    end
  end

  // A branch wins over an enable in the same cycle
  always_comb begin
    gie_next = gie_reg;
    if (take) begin
      gie_next = 1'b0; // R17
    end else if (ENABLE_IRQ_INSTR_I) begin
      gie_next = 1'b1; // R1
    end else if (DISABLE_IRQ_INSTR_I) begin
      gie_next = 1'b0; // R1
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gie_reg <= GIE_RESET;
    end else if (CE_I) begin
      gie_reg <= gie_next;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      vec_req_reg <= 1'b0;
      vec_level_reg <= '0;
    end else if (CE_I) begin
      vec_req_reg <= take; // R16
      if (take) begin
        vec_level_reg <= cand_level; // R15
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_reg <= '0;
    end else if (CE_I && PORT_REQ_I.rd) begin
      rdata_reg <= '0;
      if (PORT_REQ_I.addr == PORT_ADDR_FLAGS) begin
        rdata_reg[NUM_LEVELS-1:0] <= flag_reg; // R5 R13
      end else if (PORT_REQ_I.addr == PORT_ADDR_CTRL) begin
        rdata_reg[MASK_LSB +: NUM_LEVELS] <= mask_reg; // R10 R13
      end
    end
  end

  // Tracks handler nesting depth of one only; nested returns drop to idle
  always_comb begin
    case (state_reg)
      EIL_IDLE: state_next = take ? EIL_BRANCH : EIL_IDLE;
      EIL_BRANCH: state_next = take ? EIL_BRANCH : EIL_HANDLER;
      EIL_HANDLER: begin
        if (take) begin
          state_next = EIL_BRANCH;
        end else if (RETURN_FROM_HANDLER_I) begin
          state_next = EIL_IDLE;
        end else begin
          state_next = EIL_HANDLER;
        end
      end
      default: state_next = EIL_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= EIL_IDLE;
      hact_reg <= 1'b0;
    end else if (CE_I) begin
      state_reg <= state_next;
      // Registered copy keeps the output straight from a flop
      hact_reg <= (state_next != EIL_IDLE);
    end
  end

  assign PORT_RDATA_O = rdata_reg;
  assign VECTOR_REQ_O = vec_req_reg;
  assign VECTOR_LEVEL_O = vec_level_reg;
  assign HANDLER_ACTIVE_O = hact_reg;
  always_comb begin
    STATUS_O = '0;
    STATUS_O[STATUS_GIE_BIT] = gie_reg; // R2
  end

  logic [NUM_LEVELS-1:0] lvl_oh;
  logic [NUM_LEVELS-1:0] lvl_below;
  assign lvl_oh = LEVEL_ONE << VECTOR_LEVEL_O;
  assign lvl_below = lvl_oh - LEVEL_ONE;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_take;
    CE_I && take;
  endsequence

  sequence s_vectored;
    VECTOR_REQ_O && $past(CE_I);
  endsequence

  property p_gie_on;
    CE_I && ENABLE_IRQ_INSTR_I && !take |=> gie_reg && STATUS_O[STATUS_GIE_BIT];
  endproperty
  a_gie_on: assert property (p_gie_on) else $error("enable did not set status bit"); // R1 R2

  property p_gie_off;
    CE_I && DISABLE_IRQ_INSTR_I && !ENABLE_IRQ_INSTR_I |=> !STATUS_O[STATUS_GIE_BIT];
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("disable did not clear enable"); // R1

  property p_no_branch_disabled;
    CE_I && !gie_reg |=> !VECTOR_REQ_O;
  endproperty
  a_no_branch_disabled: assert property (p_no_branch_disabled) else $error("branch while disabled"); // R1

  property p_event_latch;
    CE_I && (ev != LEVEL_NONE) |=> (flag_reg & $past(ev)) == $past(ev);
  endproperty
  a_event_latch: assert property (p_event_latch) else $error("event not latched"); // R4 R12 R22

  property p_soft_write;
    CE_I && flag_wr && !take |=> flag_reg == ($past(PORT_REQ_I.wdata[NUM_LEVELS-1:0]) | $past(ev));
  endproperty
  a_soft_write: assert property (p_soft_write) else $error("flag write wrong"); // R13

  property p_cmp_route;
    CE_I && CMP_ENABLE_I && CMP_LEVEL_SIX_I && CMP_LEVEL_SEVEN_I |=> flag_reg[LVL_PD5F:LVL_PD4R] == 2'h3;
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("comparator event lost"); // R8

  property p_read_flags;
    CE_I && PORT_REQ_I.rd && PORT_REQ_I.addr == PORT_ADDR_FLAGS |=> PORT_RDATA_O == {8'h00, $past(flag_reg)};
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read wrong"); // R5 R13

  property p_read_mask;
    CE_I && PORT_REQ_I.rd && PORT_REQ_I.addr == PORT_ADDR_CTRL |=> PORT_RDATA_O == {8'h00, $past(mask_reg)};
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read wrong"); // R10 R13

  property p_prio;
    s_take |=> VECTOR_REQ_O && (($past(cand) & lvl_oh) != LEVEL_NONE) && (($past(cand) & lvl_below) == LEVEL_NONE);
  endproperty
  a_prio: assert property (p_prio) else $error("wrong level vectored"); // R14 R15 R16

  property p_clear_gie;
    s_take |=> !gie_reg;
  endproperty
  a_clear_gie: assert property (p_clear_gie) else $error("branch kept enable"); // R17

  property p_clear_flag;
    s_take ##1 (!$past(|(ev & svc_clr))) |-> (flag_reg & lvl_oh) == LEVEL_NONE;
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("served flag not cleared"); // R18

  property p_masked;
    s_vectored |-> ($past(mask_reg) & lvl_oh) != LEVEL_NONE && $past(gie_reg);
  endproperty
  a_masked: assert property (p_masked) else $error("masked level vectored"); // R9 R19 R11
endmodule // eil_ctrl

// ---- design/eil_prio.sv ----
`timescale 1ns/1ps
module eil_prio #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] req_i,
  output logic valid_o,
  output logic [W-1:0] level_o
);
  // Scan from lowest priority upward so the lowest index wins
  always_comb begin
    valid_o = |req_i;
    level_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        level_o = W'(i);
      end
    end
  end
endmodule // eil_prio

// ---- design/eil_sync.sv ----
`timescale 1ns/1ps
module eil_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // eil_sync

// ---- include/eil_pkg.sv ----
package eil_pkg;
  localparam int NUM_LEVELS = 8;
  localparam int LEVEL_W = 3;
  localparam int PORT_ADDR_W = 8;
  localparam int PORT_DATA_W = 16;
  localparam int STATUS_W = 16;
  localparam logic [PORT_ADDR_W-1:0] PORT_ADDR_CTRL = 8'h38;
  localparam logic [PORT_ADDR_W-1:0] PORT_ADDR_FLAGS = 8'h39;
  localparam int STATUS_GIE_BIT = 4;
  localparam int MASK_LSB = 0;
  localparam logic [NUM_LEVELS-1:0] MASK_RESET = 8'h00;
  localparam logic [NUM_LEVELS-1:0] LEVEL_ONE = 8'h01;
  localparam logic [NUM_LEVELS-1:0] LEVEL_NONE = 8'h00;
  localparam logic GIE_RESET = 1'b0;
  localparam int LVL_CONV = 0;
  localparam int LVL_TMR1 = 1;
  localparam int LVL_TMR2 = 2;
  localparam int LVL_PD2R = 3;
  localparam int LVL_PD3F = 4;
  localparam int LVL_PFF = 5;
  localparam int LVL_PD4R = 6;
  localparam int LVL_PD5F = 7;
  localparam int PD_IDX_2 = 0;
  localparam int PD_IDX_3 = 1;
  localparam int PD_IDX_4 = 2;
  localparam int PD_IDX_5 = 3;
  localparam int PD_W = 4;
  localparam int WARM_W = 3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PORT_ADDR_W-1:0] addr;
    logic [PORT_DATA_W-1:0] wdata;
  } eil_port_req_t;

  typedef enum logic [1:0] {
    EIL_IDLE = 2'b00,
    EIL_BRANCH = 2'b01,
    EIL_HANDLER = 2'b10
  } eil_svc_state_t;
endpackage

// ---- verification/eil_seq_model.sv ----
`timescale 1ns/1ps
module eil_seq_model (
  input wire logic clk_i,
  input wire logic vec_i,
  input wire logic slow_i,
  input wire logic auto_i,
  output logic ready_o,
  output logic en_o,
  output logic dis_o,
  output logic ret_o
);
  logic pend;
  initial begin
    ready_o = 1'b1;
    en_o = 1'b0;
    dis_o = 1'b0;
    ret_o = 1'b0;
  end
  // Slow sequencer accepts a vector only every other cycle
  always @(negedge clk_i) ready_o <= !slow_i || !ready_o;
  task automatic pulse_en();
    en_o = 1'b1;
    @(negedge clk_i);
    en_o = 1'b0;
  endtask
  // Disable repeated, as a prefixed instruction would be
  task automatic pulse_dis();
    dis_o = 1'b1;
    repeat (2) @(negedge clk_i);
    dis_o = 1'b0;
  endtask
  // Handler: optional re-enable just before the return
  // A vector that lands with the return is served without a gap
  always @(negedge clk_i) begin
    pend = (vec_i === 1'b1);
    while (pend) begin
      repeat (3) @(negedge clk_i);
      if (auto_i) pulse_en();
      ret_o = 1'b1;
      @(negedge clk_i);
      ret_o = 1'b0;
      pend = (vec_i === 1'b1);
    end
  end
endmodule // eil_seq_model

// ---- verification/tb_eight_level_interrupt_logic.sv ----
`timescale 1ns/1ps
module tb_eight_level_interrupt_logic;
  import eil_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  eil_port_req_t req = '0;
  logic [PORT_DATA_W-1:0] rdata;
  logic tcv = 1'b0, tt1 = 1'b0, tt2 = 1'b0, cmpen = 1'b0, c6 = 1'b0, c7 = 1'b0;
  logic [3:0] pd = 4'hA;
  logic [7:0] pf = 8'hFF;
  logic slow = 1'b0, auto_h = 1'b0;
  logic vreq, hact, ready, en, dis, ret;
  logic [LEVEL_W-1:0] vlvl;
  logic [STATUS_W-1:0] stat;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  eil_ctrl dut_u (.REF_CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .PORT_REQ_I(req),
    .PORT_RDATA_O(rdata), .ENABLE_IRQ_INSTR_I(en), .DISABLE_IRQ_INSTR_I(dis),
    .RETURN_FROM_HANDLER_I(ret), .BRANCH_READY_I(ready), .CONVERTER_TIMER_UNDERFLOW_I(tcv),
    .TIMER_ONE_UNDERFLOW_I(tt1), .TIMER_TWO_UNDERFLOW_I(tt2), .PORTD2_I(pd[0]),
    .PORTD3_I(pd[1]), .PORTD4_I(pd[2]), .PORTD5_I(pd[3]), .PORTF_I(pf),
    .CMP_ENABLE_I(cmpen), .CMP_LEVEL_SIX_I(c6), .CMP_LEVEL_SEVEN_I(c7),
    .VECTOR_REQ_O(vreq), .VECTOR_LEVEL_O(vlvl), .STATUS_O(stat), .HANDLER_ACTIVE_O(hact));
  eil_seq_model seq_u (.clk_i(clk), .vec_i(vreq), .slow_i(slow), .auto_i(auto_h),
    .ready_o(ready), .en_o(en), .dis_o(dis), .ret_o(ret));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle first so back-to-back calls never reassign req at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    chk(rdata, exp);
  endtask
  // Expected code: top bit marks a branch, low bits its level
  task automatic vec(input logic [3:0] exp);
    logic [3:0] got;
    got = 4'h0;
    for (int i = 0; i < 20 && got == 4'h0; i++) begin
      @(negedge clk);
      if (vreq === 1'b1) got = {1'b1, vlvl};
    end
    chk({12'h000, got}, {12'h000, exp});
  endtask
  // Pins are put back afterwards; the return edge is the non-triggering one
  task automatic trig(input int i);
    case (i)
      0: tcv = 1'b1;
      1: tt1 = 1'b1;
      2: tt2 = 1'b1;
      3: pd[0] = 1'b1;
      4: pd[1] = 1'b0;
      5: pf[2] = 1'b0;
      6: pd[2] = 1'b1;
      7: pd[3] = 1'b0;
      8: c6 = 1'b1;
      default: c7 = 1'b1;
    endcase
    @(negedge clk);
    {tcv, tt1, tt2, c6, c7} = 5'h00;
    repeat (5) @(negedge clk);
    pd = 4'hA;
    pf = 8'hFF;
    repeat (5) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    chk(stat, 16'h0000);
    rd(PORT_ADDR_CTRL, 16'h0000);
    wr(PORT_ADDR_FLAGS, 16'hFFA5);
    rd(PORT_ADDR_FLAGS, 16'h00A5);
    rd(8'h3A, 16'h0000);
    wr(PORT_ADDR_CTRL, 16'h00FF);
    rd(PORT_ADDR_CTRL, 16'h00FF);
    vec(4'h0);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    rd(PORT_ADDR_FLAGS, 16'h00A5);
    rd(PORT_ADDR_CTRL, 16'h0000);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      cmpen = (i >= 8);
      wr(PORT_ADDR_FLAGS, 16'h0000);
      trig(i == 10 ? 6 : i);
      rd(PORT_ADDR_FLAGS, i == 10 ? 16'h0 : (i > 7 ? 16'h40 << (i - 8) : 16'h1 << i));
    end
    cmpen = 1'b0;
    seq_u.pulse_en();
    chk(stat, 16'h0010);
    seq_u.pulse_dis();
    chk(stat, 16'h0000);
    wr(PORT_ADDR_CTRL, 16'h00FE);
    wr(PORT_ADDR_FLAGS, 16'h0001);
    seq_u.pulse_en();
    vec(4'h0);
    chk(stat, 16'h0010);
    rd(PORT_ADDR_FLAGS, 16'h0001);
    wr(PORT_ADDR_CTRL, 16'h00FF);
    vec(4'h8);
    chk({15'h0, hact}, 16'h0001);
    chk(stat, 16'h0000);
    rd(PORT_ADDR_FLAGS, 16'h0000);
    repeat (8) @(negedge clk);
    chk({15'h0, hact}, 16'h0000);
    auto_h = 1'b1;
    wr(PORT_ADDR_FLAGS, 16'h0028);
    vec(4'h0);
    seq_u.pulse_en();
    vec(4'hB);
    vec(4'hD);
    auto_h = 1'b0;
    rd(PORT_ADDR_FLAGS, 16'h0000);
    repeat (8) @(negedge clk);
    chk(stat, 16'h0000);
    chk({15'h0, hact}, 16'h0000);
    slow = 1'b1;
    tt1 = 1'b1;
    wr(PORT_ADDR_FLAGS, 16'h0000);
    tt1 = 1'b0;
    rd(PORT_ADDR_FLAGS, 16'h0002);
    seq_u.pulse_en();
    vec(4'h9);
    rd(PORT_ADDR_FLAGS, 16'h0000);
    repeat (8) @(negedge clk);
    final_report();
  end
endmodule // tb_eight_level_interrupt_logic
